/* File: tb/rtc_cmd_engine_assertions.sv */
// Purpose: Port-level checks of the tag command engine
// Assumes: Reply bit fields hold between LINK_TX_VALID pulses
// Notes:   Bound to every instance of the engine
`timescale 1ns/1ps
module rtc_cmd_engine_assertions (
	input wire logic              CLK,
	input wire logic              RST_N,
	input wire logic              LINK_CLK,
	input wire logic              FIELD_ON,
	input wire logic              LINK_TX_VALID,
	input wire rtc_pkg::rtc_txb_s LINK_TX,
	input wire logic [127:0]      TTF_FRAME,
	input wire logic              TTF_LOCKED,
	input wire logic [2:0]        TAG_STATE
);
	property p_onehot; @(posedge CLK) disable iff (!RST_N)
		$onehot(TAG_STATE); endproperty
	a_onehot: assert property (p_onehot) else $error("tag state not one-hot");
	property p_quiet_src; @(posedge CLK) disable iff (!RST_N)
		TAG_STATE == 3'h4 && $past(TAG_STATE) != 3'h4 |-> $past(TAG_STATE) == 3'h2; endproperty
	a_quiet_src: assert property (p_quiet_src) else $error("quiet not from selected");
	property p_sel_reply; @(posedge LINK_CLK) disable iff (!RST_N)
		$rose(TAG_STATE[1]) |-> ##[0:12] (LINK_TX_VALID && LINK_TX.first && !LINK_TX.data); endproperty
	a_sel_reply: assert property (p_sel_reply) else $error("select gave no success bit");
	property p_ok_bit; @(posedge LINK_CLK) disable iff (!RST_N)
		LINK_TX_VALID && LINK_TX.first && LINK_TX.last |-> !LINK_TX.data; endproperty
	a_ok_bit: assert property (p_ok_bit) else $error("one-bit reply not cleared");
	property p_err_len; @(posedge LINK_CLK) disable iff (!RST_N)
		LINK_TX_VALID && LINK_TX.first && !LINK_TX.dual && LINK_TX.data
		|-> !LINK_TX.last ##[1:12] (LINK_TX_VALID && LINK_TX.data); endproperty
	a_err_len: assert property (p_err_len) else $error("error reply without code");
	property p_last_manch; @(posedge LINK_CLK) disable iff (!RST_N)
		LINK_TX_VALID && LINK_TX.last |-> !LINK_TX.dual; endproperty
	a_last_manch: assert property (p_last_manch) else $error("final bit dual coded");
	property p_lock_sticky; @(posedge CLK) disable iff (!RST_N)
		!$fell(TTF_LOCKED); endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("identity lock released");
	property p_ttf_hold; @(posedge CLK) disable iff (!RST_N)
		FIELD_ON [*6] |-> $stable(TTF_FRAME); endproperty
	a_ttf_hold: assert property (p_ttf_hold) else $error("frame moved without field cycle");
endmodule
bind rtc_cmd_engine rtc_cmd_engine_assertions u_chk (.CLK, .RST_N, .LINK_CLK, .FIELD_ON,
	.LINK_TX_VALID, .LINK_TX, .TTF_FRAME, .TTF_LOCKED, .TAG_STATE);

/* File: tb/rtc_reader_model.sv */
// Purpose: Reader side: sends request frames, gathers reply bits
// Assumes: Frame bits right-justified, highest index sent first
// Notes:   Data line shows the inverse of the last bit outside frames
`timescale 1ns/1ps
module rtc_reader_model (
	input  wire logic              LINK_CLK,
	input  wire logic              LINK_TX_VALID,
	input  wire rtc_pkg::rtc_txb_s LINK_TX,
	output logic                   LINK_RX_SOF,
	output logic                   LINK_RX_VALID,
	output logic                   LINK_RX_BIT,
	output logic                   LINK_RX_EOF
);
	logic [159:0] rv;
	int           got;
	initial begin
		{LINK_RX_SOF, LINK_RX_VALID, LINK_RX_BIT, LINK_RX_EOF} = 4'h0;
		rv = '0;
		got = 0;
	end
	always @(posedge LINK_CLK) begin
		if (LINK_TX_VALID === 1'b1) begin
			rv  <= {rv[158:0], LINK_TX.data};
			got <= got + 1;
		end
	end
	task automatic send(input logic [159:0] f, input int n);
		rv = '0;
		got = 0;
		@(posedge LINK_CLK) #1 LINK_RX_SOF = 1'b1;
		@(posedge LINK_CLK) #1 LINK_RX_SOF = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			LINK_RX_VALID = 1'b1;
			LINK_RX_BIT = f[i];
			@(posedge LINK_CLK) #1;
		end
		LINK_RX_VALID = 1'b0;
		LINK_RX_BIT = ~LINK_RX_BIT;
		LINK_RX_EOF = 1'b1;
		@(posedge LINK_CLK) #1 LINK_RX_EOF = 1'b0;
	endtask
endmodule

/* File: tb/tb_rtc_cmd_engine.sv */
// Purpose: Self-checking bench of the tag command engine
// Assumes: Protected range 18h-36h
// Notes:   Block number and data drawn from an 8-bit LFSR
`timescale 1ns/1ps
module tb_rtc_cmd_engine;
	import rtc_pkg::*;
	localparam logic [47:0] TAG_ID = 48'hA5C3_1E0F_7B29; // Arbitrary value
	localparam logic [39:0] SER    = 40'h12_3456_789A;   // Arbitrary value
	localparam logic [7:0]  MK     = 8'h3C;              // Arbitrary value
	localparam logic [7:0]  IREF   = 8'h4D;              // Arbitrary value
	logic clk, rst_n, lclk, fld, sof, vld, rb, eof, tv, tlk, lok, busy;
	logic [2:0] st;
	logic [127:0] tag_first_mode;
	logic [7:0] r, b;
	logic [31:0] d;
	rtc_txb_s tx;
	int err_total, compares;
	rtc_cmd_engine #(.UNIQUE_ID(TAG_ID), .MAKER_SERIAL(SER), .MAKER_CODE(MK), .IC_REFERENCE(IREF))
	DUT (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .LINK_CLK(lclk), .LINK_RX_SOF(sof),
		.LINK_RX_VALID(vld), .LINK_RX_BIT(rb), .LINK_RX_EOF(eof), .FIELD_ON(fld), .PROT_EN(1'b1),
		.PROT_RD(1'b0), .PROT_LO(8'h18), .PROT_HI(8'h36), .LINK_TX_VALID(tv), .LINK_TX(tx),
		.TTF_FRAME(tag_first_mode), .TTF_LOCKED(tlk), .TAG_STATE(st), .LOGIN_OK(lok), .BUSY(busy));
	rtc_reader_model rdr (.LINK_CLK(lclk), .LINK_TX_VALID(tv), .LINK_TX(tx), .LINK_RX_SOF(sof),
		.LINK_RX_VALID(vld), .LINK_RX_BIT(rb), .LINK_RX_EOF(eof));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#37 forever #80 lclk = ~lclk;
	end
	function automatic logic [7:0] nx(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input string nm, input logic [159:0] e, input logic [159:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Silent requests end once BUSY drops past the reply deadline
	task automatic xa(input string nm, input logic [159:0] f, input int n,
		input logic [159:0] e, input int en);
		int i;
		rdr.send(f, n);
		for (i = 0; i < 1500 && !(i > 12 && rdr.got == en && busy === 1'b0); i++)
			@(posedge lclk);
		chk(nm, e, rdr.rv);
		chk(nm, en, rdr.got);
		$display("Test %s done", nm);
	endtask
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#2000000;
		err_total++;
		test_done;
	end
	initial begin
		{rst_n, fld, r, err_total, compares} = {1'b0, 1'b1, 8'h32, 64'h0};
		repeat (3) @(posedge lclk);
		@(posedge clk) #1 rst_n = 1'b1;
		repeat (4) @(posedge lclk);
		chk("reset", 160'h1, {tlk, lok, busy, st});
		for (int k = 0; k < 5; k++) begin
			r = nx(r);
			d = {d[23:0], r};
		end
		b = r % 8'h18;
		xa("sysinfo", {5'h00, CMD_SYSI}, 11, {1'b0, SER, MK, IREF, 48'h0}, 105);
		xa("unsupported", {5'h00, 6'h3F}, 11, 0, 0);
		xa("crc", {5'h04, CMD_LOCK, 8'h00, 16'h0}, 35, {4'hF, 16'hF1EF}, 20);
		xa("write", {5'h00, CMD_WRSB, b, d}, 51, 0, 1);
		xa("inventory", {5'h12, CMD_RDMB, 6'h00, b, 8'h00}, 33, {TAG_ID, 1'b0, d}, 81);
		xa("inv_x", {5'h12, CMD_RDMB, 6'h01, ~TAG_ID[0], b, 8'h00}, 34, 0, 0);
		xa("lock_nologin", {5'h00, CMD_LOCK, 8'h20}, 19, 160'hF, 4);
		xa("login_bad", {5'h00, CMD_LOGIN, MK, ~PWD_DEFAULT}, 51, 160'hF, 4);
		chk("login_flag", 0, lok);
		xa("login", {5'h00, CMD_LOGIN, MK, PWD_DEFAULT}, 51, 0, 1);
		chk("login_flag", 1, lok);
		xa("lock_group", {5'h00, CMD_LOCK, 8'h20}, 19, 0, 1);
		xa("write_group", {5'h00, CMD_WRSB, 8'h36, d}, 51, 160'hF, 4);
		xa("lock", {5'h00, CMD_LOCK, b}, 19, 0, 1);
		xa("write_locked", {5'h00, CMD_WRSB, b, ~d}, 51, 160'hF, 4);
		xa("write_peer", {5'h00, CMD_WRSB, b ^ 8'h01, d}, 51, 0, 1);
		xa("ident", {5'h00, CMD_TTFL, {4{d}}}, 139, 0, 1);
		chk("ttf_lock", 1, tlk);
		chk("ttf_staged", 0, tag_first_mode);
		#1 fld = 1'b0;
		repeat (8) @(posedge clk);
		#1 fld = 1'b1;
		repeat (8) @(posedge clk);
		chk("ttf_frame", {4{d}}, tag_first_mode);
		xa("select", {5'h10, CMD_SEL, TAG_ID}, 59, 0, 1);
		chk("state", 160'h2, st);
		xa("select_other", {5'h10, CMD_SEL, ~TAG_ID}, 59, 0, 0);
		chk("state", 160'h4, st);
		xa("select_quiet", {5'h10, CMD_SEL, ~TAG_ID}, 59, 0, 0);
		chk("state", 160'h4, st);
		test_done;
	end
endmodule

/* File: verilog/rtc_cmd_engine.sv */
// Purpose: Tag-side command interpreter: decode, state, memory, reply stream
// Assumes: Front end delivers demodulated request bits and codes reply bits on LINK_CLK
// Notes:   Half duplex; a request is taken only while no reply is in progress
//
// Functional notes
// - Inventory block read: flags, 6-bit mask length, mask, first block, count.
// - Any error during an inventory block read gives no reply at all.
// - Inventory reply: unmasked identifier in dual pattern, rest Manchester coded.
// - Inventory reply data holds 32 bits per requested block before the CRC.
// - Good single-block write stores 32 bits and replies success.
// - Good lock request write-protects the addressed block permanently.
// - Blocks 00h-17h, FEh and FFh each own an independent lock.
// - Locking any block 18h-36h locks the whole 18h-36h group.
// - With password protection enabled, locking needs a prior successful login.
// - Select with own identifier enters selected state and replies success.
// - Ready or quiet tag ignores select with foreign identifier silently.
// - Selected tag given a foreign select drops to quiet silently.
// - In ready state the identity write stores the 128-bit frame unchecked.
// - Code 111000 stores only; 111001 stores then locks the identity area.
// - Identity write takes effect after field reset; new frame then broadcast.
// - System information reply: serial, maker code, IC reference, six zero bytes.
// - Login checks maker code and compares password with block FEh; both matching grants protected access.
// - A later login with wrong password withdraws protected access.
// - Success reply is one cleared error bit plus optional CRC.
// - Failure reply is error bit set, code 111, optional CRC.
// - Unsupported command codes get no reply.
// - CRC-16 uses polynomial 1021h, preset 0000h.
`timescale 1ns/1ps
module rtc_cmd_engine #(
	parameter logic [47:0] UNIQUE_ID    = 48'h0123_4567_89AB, // Arbitrary value
	parameter logic [39:0] MAKER_SERIAL = 40'h00_0000_0001,   // Arbitrary value
	parameter logic [7:0]  MAKER_CODE   = 8'h5A,              // Arbitrary value
	parameter logic [7:0]  IC_REFERENCE = 8'h01               // Arbitrary value
) (
	input  logic                  CLK,
	input  logic                  RST_N,
	input  logic                  CE,
	input  logic                  LINK_CLK,
	input  logic                  LINK_RX_SOF,
	input  logic                  LINK_RX_VALID,
	input  logic                  LINK_RX_BIT,
	input  logic                  LINK_RX_EOF,
	input  logic                  FIELD_ON,
	input  logic                  PROT_EN,
	input  logic                  PROT_RD,
	input  logic [7:0]            PROT_LO,
	input  logic [7:0]            PROT_HI,
	output logic                  LINK_TX_VALID,
	output rtc_pkg::rtc_txb_s     LINK_TX,
	output logic [127:0]          TTF_FRAME,
	output logic                  TTF_LOCKED,
	output logic [2:0]            TAG_STATE,
	output logic                  LOGIN_OK,
	output logic                  BUSY
);
	import rtc_pkg::*;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Field of w bits at pos, first received bit ends up as MSB
	function automatic logic [TTF_W-1:0] fld(input logic [FRM_BITS-1:0] f,
		input int pos, input int w);
		logic [TTF_W-1:0] r;
		r = '0;
		for (int i = 0; i < TTF_W; i++) begin
			if (i < w && pos + i < FRM_BITS) begin
				r = {r[TTF_W-2:0], f[pos+i]};
			end
		end
		return r;
	endfunction

	function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
		return {c[CRC_W-2:0], 1'b0} ^ ((c[CRC_W-1] ^ b) ? CRC_POLY : CRC_INIT);
	endfunction

	// ----------------------------------------------------------------
	// Link domain: reset/enable synchronisers, request capture
	// ----------------------------------------------------------------
	logic                 lrst_m, lrst_s, lce_m, lce_s;
	logic [FRM_BITS-1:0]  frm_r;
	logic [7:0]           cnt_r;
	logic [CRC_W-1:0]     rcrc_r, tcrc_r;
	logic                 rx_tgl_r, ack_tgl_r;
	logic                 tt_m, tt_s, tt_p;
	logic [4:0]           crc_left_r;
	rtc_txb_s             txb_r;
	logic                 tx_tgl_r;

	always_ff @(posedge LINK_CLK) begin
		lrst_m <= RST_N;
		lrst_s <= lrst_m;
		lce_m  <= CE;
		lce_s  <= lce_m;
	end

	always_ff @(posedge LINK_CLK) begin
		if (!lrst_s) begin
			frm_r    <= '0;
			cnt_r    <= '0;
			rcrc_r   <= CRC_INIT;
			rx_tgl_r <= 1'b0;
		end else if (lce_s) begin
			if (LINK_RX_SOF) begin
				cnt_r  <= '0;
				rcrc_r <= CRC_INIT;
			end else if (LINK_RX_VALID) begin
				if (int'(cnt_r) < FRM_BITS) begin
					frm_r[cnt_r] <= LINK_RX_BIT;
				end
				cnt_r  <= (cnt_r == CNT_MAX) ? cnt_r : cnt_r + 8'h01;
				rcrc_r <= crc_step(rcrc_r, LINK_RX_BIT);
			end
			if (LINK_RX_EOF) begin
				rx_tgl_r <= ~rx_tgl_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// Link domain: reply bit emission and reply CRC
	// ----------------------------------------------------------------
	// Each reply bit is handed over with a toggle; the core holds txb_r
	// until the acknowledge toggle returns, so the word is stable here.
	always_ff @(posedge LINK_CLK) begin
		if (!lrst_s) begin
			tt_m          <= 1'b0;
			tt_s          <= 1'b0;
			tt_p          <= 1'b0;
			tcrc_r        <= CRC_INIT;
			crc_left_r    <= '0;
			ack_tgl_r     <= 1'b0;
			LINK_TX_VALID <= 1'b0;
			LINK_TX       <= '0;
		end else if (lce_s) begin
			tt_m <= tx_tgl_r;
			tt_s <= tt_m;
			tt_p <= tt_s;
			LINK_TX_VALID <= 1'b0;
			if (tt_s ^ tt_p) begin
				LINK_TX_VALID <= 1'b1;
				LINK_TX       <= txb_r;
				LINK_TX.last  <= txb_r.last && !txb_r.crc;
				tcrc_r <= crc_step(txb_r.first ? CRC_INIT : tcrc_r, txb_r.data);
				if (txb_r.last && txb_r.crc) begin
					crc_left_r <= CRC_BITS;
				end else begin
					ack_tgl_r <= ~ack_tgl_r;
				end
			end else if (crc_left_r != '0) begin
				LINK_TX_VALID <= 1'b1;
				LINK_TX.data  <= tcrc_r[CRC_W-1];
				LINK_TX.dual  <= 1'b0;
				LINK_TX.first <= 1'b0;
				LINK_TX.last  <= (crc_left_r == 5'h01);
				tcrc_r        <= {tcrc_r[CRC_W-2:0], 1'b0};
				crc_left_r    <= crc_left_r - 5'h01;
				if (crc_left_r == 5'h01) begin
					ack_tgl_r <= ~ack_tgl_r;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Core domain: synchronisers and request capture
	// ----------------------------------------------------------------
	rtc_core_state_e      cs_r;
	rtc_tag_state_e       ts_r;
	rtc_phase_e           ph_r;
	logic                 rx_m, rx_s, rx_p, ack_m, ack_s, ack_p, fo_m, fo_s, fo_p;
	logic [FRM_BITS-1:0]  req_r;
	logic [7:0]           rlen_r;
	logic                 rcrc_ok_r, login_r;
	logic [SH_W-1:0]      sh_r;
	logic [7:0]           left_r, blk_r;
	logic [8:0]           nblk_r;
	logic                 first_r, crcq_r, multi_r;
	logic [SLOT_W-1:0]    slot_r;
	logic [IND_LOCKS-1:0] lk_ind_r;
	logic                 lk_grp_r, lk_pwd_r, lk_top_r, ttf_lock_r;
	logic [BLK_W-1:0]     pwd_r;
	logic [TTF_W-1:0]     ttf_stage_r;
	logic [BLK_W-1:0]     mem [0:MEM_DEPTH-1];

	wire rx_new   = rx_s ^ rx_p;
	wire ack_new  = ack_s ^ ack_p;
	wire fld_rise = fo_s & ~fo_p;
	wire fld_fall = ~fo_s & fo_p;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			{rx_m, rx_s, rx_p, ack_m, ack_s, ack_p} <= '0;
			{fo_m, fo_s, fo_p} <= '0;
		end else if (CE) begin
			{rx_m, rx_s, rx_p}    <= {rx_tgl_r, rx_m, rx_s};
			{ack_m, ack_s, ack_p} <= {ack_tgl_r, ack_m, ack_s};
			{fo_m, fo_s, fo_p}    <= {FIELD_ON, fo_m, fo_s};
		end
	end

	// ----------------------------------------------------------------
	// Core domain: request decode
	// ----------------------------------------------------------------
	int               ub, cb, exp_len;
	logic [4:0]       flg;
	logic [5:0]       cmd, mlen;
	logic [47:0]      uid_rx, mask, lowmask;
	logic [7:0]       blk, mfc_rx, first_blk, nblk;
	logic [31:0]      wdata, pwd_rx;
	logic [TTF_W-1:0] ttf_rx;
	logic [8:0]       inv_last;

	assign flg       = FLG_W'(fld(req_r, POS_FLG, FLG_W));
	assign cmd       = CMD_W'(fld(req_r, POS_CMD, CMD_W));
	assign ub        = flg[FLG_ADR] ? UID_W : 0;
	assign cb        = flg[FLG_CRC] ? CRC_W : 0;
	assign uid_rx    = UID_W'(fld(req_r, (cmd == CMD_LOGIN) ? POS_LOG_UID : POS_ARG, UID_W));
	assign blk       = BYTE_W'(fld(req_r, POS_ARG + ub, BYTE_W));
	assign wdata     = BLK_W'(fld(req_r, POS_ARG + ub + BYTE_W, BLK_W));
	assign mfc_rx    = BYTE_W'(fld(req_r, POS_ARG, BYTE_W));
	assign pwd_rx    = BLK_W'(fld(req_r, POS_LOG_UID + ub, BLK_W));
	assign ttf_rx    = fld(req_r, POS_ARG, TTF_W);
	assign mlen      = MLEN_W'(fld(req_r, POS_ARG, MLEN_W));
	assign mask      = UID_W'(fld(req_r, POS_ARG + MLEN_W, int'(mlen)));
	assign first_blk = BYTE_W'(fld(req_r, POS_ARG + MLEN_W + int'(mlen), BYTE_W));
	assign nblk      = BYTE_W'(fld(req_r, POS_ARG + MLEN_W + int'(mlen) + BYTE_W, BYTE_W));
	assign lowmask   = ~({UID_W{1'b1}} << mlen);
	assign inv_last  = {1'b0, first_blk} + {1'b0, nblk};

	// Expected frame length per command; a mismatch counts as a frame error
	assign exp_len =
		(cmd == CMD_WRSB)  ? POS_ARG + ub + BYTE_W + BLK_W + cb :
		(cmd == CMD_LOCK)  ? POS_ARG + ub + BYTE_W + cb :
		(cmd == CMD_SEL)   ? POS_ARG + UID_W + cb :
		(cmd == CMD_SYSI)  ? POS_ARG + ub + cb :
		(cmd == CMD_LOGIN) ? POS_LOG_UID + ub + BLK_W + cb :
		(cmd == CMD_RDMB)  ? POS_ARG + MLEN_W + int'(mlen) + 2 * BYTE_W + cb :
		POS_ARG + TTF_W + cb;

	wire crc_bad  = flg[FLG_CRC] & ~rcrc_ok_r;
	wire frm_bad  = crc_bad | (int'(rlen_r) != exp_len);
	wire addr_mis = flg[FLG_ADR] & (uid_rx != UNIQUE_ID);
	wire ign      = addr_mis | (flg[FLG_SEL] & (ts_r != TS_SEL)) |
		((ts_r == TS_QUIET) & ~flg[FLG_ADR]);

	// ----------------------------------------------------------------
	// Core domain: per-command outcome
	// ----------------------------------------------------------------
	wire blk_ok   = (blk <= BLK_GRP_HI) | (blk == BLK_PWD) | (blk == BLK_TOP);
	wire blk_lock = (blk <= BLK_IND_HI) ? lk_ind_r[blk[4:0]] :
		(blk <= BLK_GRP_HI) ? lk_grp_r : (blk == BLK_PWD) ? lk_pwd_r : lk_top_r;
	wire blk_prot = PROT_EN & (blk >= PROT_LO) & (blk <= PROT_HI);

	wire is_wr   = (cmd == CMD_WRSB) & ~ign;
	wire is_lk   = (cmd == CMD_LOCK) & ~ign;
	wire is_sel  = (cmd == CMD_SEL);
	wire is_sys  = (cmd == CMD_SYSI) & ~ign;
	wire is_log  = (cmd == CMD_LOGIN) & ~ign;
	wire is_ttf  = (cmd == CMD_TTF) | (cmd == CMD_TTFL);
	wire is_inv  = (cmd == CMD_RDMB) & flg[FLG_INV];

	wire wr_go   = is_wr & ~frm_bad & blk_ok & ~blk_lock & ~(blk_prot & ~login_r);
	wire lk_go   = is_lk & ~frm_bad & blk_ok & ~blk_lock & ~(PROT_EN & ~login_r);
	// Only the addressed, non-selected, non-inventory form is accepted
	wire sel_frm = is_sel & ~frm_bad & flg[FLG_ADR] & ~flg[FLG_SEL] & ~flg[FLG_INV];
	wire sel_hit = sel_frm & (uid_rx == UNIQUE_ID);
	wire sel_drp = sel_frm & (uid_rx != UNIQUE_ID) & (ts_r == TS_SEL);
	wire log_go  = is_log & ~frm_bad & (mfc_rx == MAKER_CODE) & (pwd_rx == pwd_r);
	wire log_bad = is_log & ~frm_bad & (pwd_rx != pwd_r);
	wire ttf_go  = is_ttf & ~frm_bad & ~ttf_lock_r & (ts_r == TS_READY);
	wire sys_go  = is_sys & ~frm_bad;

	wire rd_prot = PROT_EN & PROT_RD & ~login_r &
		~((inv_last < {1'b0, PROT_LO}) | (first_blk > PROT_HI));
	wire rng_ok  = (inv_last <= {1'b0, BLK_GRP_HI}) | ((nblk == '0) & (first_blk == BLK_TOP));
	wire inv_go  = is_inv & (ts_r == TS_READY) & ~frm_bad & (int'(mlen) <= UID_W) &
		rng_ok & ~rd_prot & (((UNIQUE_ID ^ mask) & lowmask) == '0);

	wire rep_ok  = wr_go | lk_go | sel_hit | log_go | ttf_go;
	// Unsupported codes and ignored write, lock, sysinfo and login requests fall through to no reply
	wire rep_err = (is_wr & ~wr_go) | (is_lk & ~lk_go) | (is_sel & ~sel_frm) |
		(is_sys & frm_bad) | (is_log & ~log_go) | (is_ttf & ~ttf_go);
	wire rep_any = rep_ok | rep_err | sys_go | inv_go;

	// ----------------------------------------------------------------
	// Core domain: reply vectors
	// ----------------------------------------------------------------
	wire [SH_W-1:0] sh_ok  = {1'b0, {(SH_W-1){1'b0}}};
	wire [SH_W-1:0] sh_err = {1'b1, ERR_CODE, {(SH_W-1-ECODE_W){1'b0}}};
	wire [SH_W-1:0] sh_sys = {1'b0, MAKER_SERIAL, MAKER_CODE, IC_REFERENCE,
		{(SH_W-SYS_HEAD){1'b0}}};
	wire [SH_W-1:0] sh_uid = {UNIQUE_ID, {(SH_W-UID_W){1'b0}}};
	wire            uid_ph = inv_go & (int'(mlen) < UID_W);

	wire [SH_W-1:0] ld_sh   = uid_ph ? sh_uid : (sys_go ? sh_sys : (rep_err ? sh_err : sh_ok));
	wire [7:0]      ld_left = uid_ph ? 8'(UID_W - int'(mlen)) :
		(sys_go ? SYS_LEN : (rep_err ? LEFT_ERR : LEFT_ONE));
	wire [BLK_W-1:0] rd_word = mem[blk_r];
	wire more    = (ph_r == PH_UID) | (nblk_r != '0);
	wire bit_end = (left_r == LEFT_ONE);

	// ----------------------------------------------------------------
	// Core domain: sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cs_r      <= CS_IDLE;
			req_r     <= '0;
			rlen_r    <= '0;
			rcrc_ok_r <= 1'b0;
			sh_r      <= '0;
			left_r    <= '0;
			ph_r      <= PH_BODY;
			blk_r     <= '0;
			nblk_r    <= '0;
			first_r   <= 1'b0;
			crcq_r    <= 1'b0;
			multi_r   <= 1'b0;
			slot_r    <= '0;
			txb_r     <= '0;
			tx_tgl_r  <= 1'b0;
		end else if (CE) begin
			case (cs_r)
				CS_IDLE: begin
					if (rx_new) begin
						// Link holds its frame until the next start of frame
						req_r     <= frm_r;
						rlen_r    <= cnt_r;
						rcrc_ok_r <= (rcrc_r == CRC_INIT);
						cs_r      <= CS_EXEC;
					end
				end
				CS_EXEC: begin
					sh_r    <= ld_sh;
					left_r  <= ld_left;
					ph_r    <= uid_ph ? PH_UID : PH_BODY;
					blk_r   <= first_blk;
					nblk_r  <= inv_go ? ({1'b0, nblk} + 9'h001) : '0;
					first_r <= 1'b1;
					crcq_r  <= flg[FLG_CRC];
					multi_r <= inv_go & ~flg[FLG_ADR];
					slot_r  <= SLOT_W'(UNIQUE_ID >> mlen);
					cs_r    <= rep_any ? CS_SEND : CS_IDLE;
				end
				CS_SEND: begin
					txb_r    <= '{first: first_r, last: bit_end & ~more, crc: crcq_r,
						multi: multi_r, slot: slot_r, dual: (ph_r == PH_UID),
						data: sh_r[SH_W-1]};
					tx_tgl_r <= ~tx_tgl_r;
					first_r  <= 1'b0;
					cs_r     <= CS_WAIT;
				end
				CS_WAIT: begin
					if (ack_new) begin
						cs_r <= CS_SEND;
						if (!bit_end) begin
							sh_r   <= {sh_r[SH_W-2:0], 1'b0};
							left_r <= left_r - 8'h01;
						end else if (ph_r == PH_UID) begin
							sh_r   <= sh_ok;
							left_r <= LEFT_ONE;
							ph_r   <= PH_BODY;
						end else if (nblk_r != '0) begin
							sh_r   <= {rd_word, {(SH_W-BLK_W){1'b0}}};
							left_r <= LEFT_BLK;
							ph_r   <= PH_DATA;
							blk_r  <= blk_r + 8'h01;
							nblk_r <= nblk_r - 9'h001;
						end else begin
							cs_r <= CS_IDLE;
						end
					end
				end
				default: cs_r <= CS_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Core domain: session state and login
	// ----------------------------------------------------------------
	wire exec = (cs_r == CS_EXEC);

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ts_r    <= TS_READY;
			login_r <= 1'b0;
		end else if (CE) begin
			if (fld_fall) begin
				ts_r    <= TS_READY;
				login_r <= 1'b0;
			end else if (exec) begin
				if (sel_hit) begin
					ts_r <= TS_SEL;
				end else if (sel_drp) begin
					ts_r <= TS_QUIET;
				end
				if (log_go) begin
					login_r <= 1'b1;
				end else if (log_bad) begin
					login_r <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Core domain: non-volatile image, locks and identity frame
	// ----------------------------------------------------------------
	// The array models EEPROM content and is deliberately not reset
	always_ff @(posedge CLK) begin
		if (CE && exec && wr_go && blk != BLK_PWD) begin
			mem[blk] <= wdata;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			lk_ind_r    <= '0;
			lk_grp_r    <= 1'b0;
			lk_pwd_r    <= 1'b0;
			lk_top_r    <= 1'b0;
			pwd_r       <= PWD_DEFAULT;
			ttf_stage_r <= '0;
			ttf_lock_r  <= 1'b0;
		end else if (CE && exec) begin
			if (wr_go && blk == BLK_PWD) begin
				pwd_r <= wdata;
			end
			if (lk_go) begin
				if (blk <= BLK_IND_HI) begin
					lk_ind_r[blk[4:0]] <= 1'b1;
				end else if (blk <= BLK_GRP_HI) begin
					lk_grp_r <= 1'b1;
				end else if (blk == BLK_PWD) begin
					lk_pwd_r <= 1'b1;
				end else begin
					lk_top_r <= 1'b1;
				end
			end
			if (ttf_go) begin
				ttf_stage_r <= ttf_rx;
				ttf_lock_r  <= (cmd == CMD_TTFL);
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// The broadcast frame only changes when the field comes back
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			TTF_FRAME  <= '0;
			TTF_LOCKED <= 1'b0;
			TAG_STATE  <= TS_READY;
			LOGIN_OK   <= 1'b0;
			BUSY       <= 1'b0;
		end else if (CE) begin
			if (fld_rise) begin
				TTF_FRAME <= ttf_stage_r;
			end
			TTF_LOCKED <= ttf_lock_r;
			TAG_STATE  <= ts_r;
			LOGIN_OK   <= login_r;
			BUSY       <= (cs_r != CS_IDLE);
		end
	end

endmodule

/* File: verilog/rtc_pkg.sv */
// Purpose: Shared constants and types of the RFID tag command engine
// Assumes: Request bits are stored first-received at index 0
// Notes:   Field values are read first-received bit as MSB
package rtc_pkg;

	// ----------------------------------------------------------------
	// Frame geometry
	// ----------------------------------------------------------------
	localparam int FRM_BITS    = 160;
	localparam int UID_W       = 48;
	localparam int BLK_W       = 32;
	localparam int TTF_W       = 128;
	localparam int CRC_W       = 16;
	localparam int SH_W        = 128;
	localparam int BYTE_W      = 8;
	localparam int FLG_W       = 5;
	localparam int CMD_W       = 6;
	localparam int MLEN_W      = 6;
	localparam int SLOT_W      = 4;
	localparam int ECODE_W     = 3;
	localparam int POS_FLG     = 0;
	localparam int POS_CMD     = 5;
	localparam int POS_ARG     = 11;
	localparam int POS_LOG_UID = 19;
	localparam int SYS_HEAD    = 57;
	localparam logic [7:0] SYS_LEN   = 8'h69;
	localparam logic [7:0] CNT_MAX   = 8'hFF;
	localparam logic [7:0] LEFT_ONE  = 8'h01;
	localparam logic [7:0] LEFT_ERR  = 8'h04;
	localparam logic [7:0] LEFT_BLK  = 8'h20;
	localparam logic [4:0] CRC_BITS  = 5'h10;

	// ----------------------------------------------------------------
	// Flag positions inside the 5-bit flag field (first bit = bit 4)
	// ----------------------------------------------------------------
	localparam int FLG_ADR = 4;
	localparam int FLG_SEL = 3;
	localparam int FLG_CRC = 2;
	localparam int FLG_INV = 1;

	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [5:0] CMD_RDMB  = 6'h12;
	localparam logic [5:0] CMD_WRSB  = 6'h14;
	localparam logic [5:0] CMD_LOCK  = 6'h16;
	localparam logic [5:0] CMD_SYSI  = 6'h17;
	localparam logic [5:0] CMD_SEL   = 6'h18;
	localparam logic [5:0] CMD_LOGIN = 6'h28;
	localparam logic [5:0] CMD_TTF   = 6'h38;
	localparam logic [5:0] CMD_TTFL  = 6'h39;

	// ----------------------------------------------------------------
	// Memory map, reset values, CRC
	// ----------------------------------------------------------------
	localparam logic [7:0]  BLK_IND_HI  = 8'h17;
	localparam logic [7:0]  BLK_GRP_HI  = 8'h36;
	localparam logic [7:0]  BLK_PWD     = 8'hFE;
	localparam logic [7:0]  BLK_TOP     = 8'hFF;
	localparam int          MEM_DEPTH   = 256;
	localparam int          IND_LOCKS   = 24;
	localparam logic [31:0] PWD_DEFAULT = 32'h0FFF_FFFF;
	localparam logic [2:0]  ERR_CODE    = 3'h7;
	localparam logic [15:0] CRC_POLY    = 16'h1021;
	localparam logic [15:0] CRC_INIT    = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TS_READY = 3'b001,
		TS_SEL   = 3'b010,
		TS_QUIET = 3'b100
	} rtc_tag_state_e;

	typedef enum logic [3:0] {
		CS_IDLE = 4'b0001,
		CS_EXEC = 4'b0010,
		CS_SEND = 4'b0100,
		CS_WAIT = 4'b1000
	} rtc_core_state_e;

	typedef enum logic [2:0] {
		PH_UID  = 3'b001,
		PH_BODY = 3'b010,
		PH_DATA = 3'b100
	} rtc_phase_e;

	typedef struct packed {
		logic              first;
		logic              last;
		logic              crc;
		logic              multi;
		logic [SLOT_W-1:0] slot;
		logic              dual;
		logic              data;
	} rtc_txb_s;

endpackage
